// *** pkg/calu_pkg.sv ***
// Constants, field positions and encodings of the ALU status datapath.
package calu_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_CTRL = 8'h04;
	localparam logic [7:0] A_OPA = 8'h08;
	localparam logic [7:0] A_OPB = 8'h0C;
	localparam logic [7:0] A_OPM = 8'h10;
	localparam logic [7:0] A_DHI = 8'h14;
	localparam logic [7:0] A_CMD = 8'h18;
	localparam logic [7:0] A_RLO = 8'h1C;
	localparam logic [7:0] A_RHI = 8'h20;
	localparam logic [7:0] A_MISC = 8'h24;
	localparam logic [7:0] A_PADR = 8'h28;
	localparam int SB_DC = 8;
	localparam int SB_IPL = 5;
	localparam int SB_N = 3;
	localparam int SB_OV = 2;
	localparam int SB_Z = 1;
	localparam int SB_C = 0;
	localparam int CB_CPU_PRIORITY_HIGH_BIT = 3;
	localparam logic [15:0] CTRL_FIXED = 16'h0004;
	localparam int MB_NESTING_DISABLE = 0;
	localparam int MB_BUSY = 1;
	localparam int MB_DST = 2;
	localparam int MB_ERR = 3;
	localparam int PB_TBL = 24;
	localparam int PB_PAGE = 25;
	localparam int PB_OK = 31;
	localparam int CF_BYTE = 4;
	localparam int CF_SRCM = 5;
	localparam int CF_DSTM = 6;
	localparam int CF_MUL = 8;
	localparam int CF_DSGN = 11;
	localparam int CF_DLONG = 12;
	localparam logic [4:0] DIV_CYCLES = 5'h13;
	localparam logic [4:0] DIV_LAST = 5'h0F;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_ADDC = 4'h1, OP_SUB = 4'h2, OP_SUBB = 4'h3,
		OP_AND = 4'h4, OP_IOR = 4'h5, OP_XOR = 4'h6, OP_ASR = 4'h7,
		OP_LSR = 4'h8, OP_SL = 4'h9, OP_MUL = 4'hA, OP_DIV = 4'hB
	} calu_op_t;
	typedef enum logic [2:0] {
		MM_SS = 3'h0, MM_UU = 3'h1, MM_SU = 3'h2, MM_US = 3'h3,
		MM_SL = 3'h4, MM_UL = 3'h5, MM_B8 = 3'h6
	} calu_mmode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_DIV = 2'h1, ST_FIX = 2'h3
	} calu_state_t;
endpackage

// *** rtl/calu_datapath.sv ***
// ALU, multiplier, divide assist and status word behind an AXI4-Lite slave.
// Notes on behaviour
// - Half carry: out of bit 3 for bytes, bit 7 for words.
// - Status bits 7..5 hold priority low bits; 7 blocks user interrupts.
// - Software priority low bit writes ignored while nesting disable is set.
// - Effective level is control high bit over the three low bits.
// - Control bit 3: software clears only, hardware sets or clears, resets 0.
// - Status bit 4 mirrors the repeat loop, read only, resets 0.
// - Negative flag follows the result sign.
// - Overflow flag marks signed two's complement overflow.
// - Zero flag is sticky for carry-chained operations.
// - Carry flag is carry out of the size's top bit.
// - Subtraction yields carry and half carry as inverted borrows.
// - Fixed and unused bits of both words read as documented.
// - Add, subtract, shift and logic in byte or word size.
// - Operand from register or memory; result tagged for either.
// - Seventeen bit multiplier with seven sign and size modes.
// - Divide leaves quotient and remainder in their registers.
// - Divisor from operand B register only; dividend upper half from higher register.
// - One iteration per divisor bit for both dividend sizes.
// - Multi-bit shift of up to fifteen places in one cycle.
// - Multi-bit shifts only between working registers.
// - Arithmetic right, logical right and left shifts.
// - Program addresses are 24 bits wide.
// - User program access below 800000h unless privileged table access.
// - An unheld divide takes 19 cycles; it may be held at any cycle, one cycle longer per held cycle.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module calu_datapath (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [calu_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [calu_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic loop_active,
	input wire logic hw_ipl_load,
	input wire logic [3:0] hw_ipl_value,
	input wire logic div_hold,
	output logic [3:0] cpu_priority_level,
	output logic alu_busy,
	output logic result_to_mem,
	output logic prog_access_ok
);
	import calu_pkg::*;

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic dc;
		logic [2:0] ipl;
		logic ra;
		logic n;
		logic ov;
		logic z;
		logic c;
		logic cpu_priority_high_bit;
		logic nesting_disable;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] opm;
		logic [15:0] dhi;
		logic [15:0] cmd;
		logic [15:0] res_lo;
		logic [15:0] res_hi;
		logic dst;
		logic err;
		logic [23:0] padr;
		logic ptbl;
		logic ppage;
		logic pok;
		calu_state_t st;
		logic [4:0] cnt;
		logic [15:0] rem;
		logic [15:0] quo;
		logic [15:0] dvs;
		logic neg_q;
		logic neg_r;
	} calu_st_t;

	calu_st_t s_r, s_nxt;

	function automatic logic [15:0] wmerge(input logic [15:0] o,
			input logic [31:0] d, input logic [3:0] b);
		wmerge = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
	endfunction

	function automatic logic [15:0] status_word(input calu_st_t q);
		status_word = 16'({q.dc, q.ipl, q.ra, q.n, q.ov, q.z, q.c});
	endfunction

	function automatic logic [15:0] ctrl_word(input calu_st_t q);
		ctrl_word = CTRL_FIXED | (16'(q.cpu_priority_high_bit) << CB_CPU_PRIORITY_HIGH_BIT);
	endfunction

	logic aw_fire, w_fire, wr_go, exec;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [15:0] a, b, bx, r, sh_src, w16;
	logic [3:0] op;
	logic byte_op, cin, sub_op, is_shift, cmd_ok;
	logic [4:0] s5;
	logic [8:0] s9;
	logic [16:0] s17, t;
	logic sgn, zer, cv, hv, ovv;
	logic [8:0] aff;
	logic [16:0] ma, mb;
	logic [33:0] prod;
	logic dsg;
	logic [31:0] dvd, absd;
	logic [15:0] qf, rf;

	assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign cpu_priority_level = {s_r.cpu_priority_high_bit, s_r.ipl};
	assign alu_busy = s_r.st != ST_IDLE;
	assign result_to_mem = s_r.dst;
	assign prog_access_ok = s_r.pok;

	always_comb begin
		s_nxt = s_r;
		aw_fire = s_axi_awvalid && s_axi_awready;
		w_fire = s_axi_wvalid && s_axi_wready;
		wr_go = (s_r.aw_have || aw_fire) && (s_r.w_have || w_fire);
		wa = s_r.aw_have ? s_r.aw_addr : s_axi_awaddr;
		wd = s_r.w_have ? s_r.w_data : s_axi_wdata;
		ws = s_r.w_have ? s_r.w_strb : s_axi_wstrb;
		w16 = wmerge(16'h0000, wd, ws);
		s_nxt.ra = loop_active;
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (aw_fire) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_fire) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		// Operand fetch and the add/subtract chain for both sizes.
		op = w16[3:0];
		byte_op = w16[CF_BYTE];
		a = w16[CF_SRCM] ? s_r.opm : s_r.opa;
		b = s_r.opb;
		sub_op = op == OP_SUB || op == OP_SUBB;
		bx = sub_op ? ~b : b;
		cin = (op == OP_ADDC || op == OP_SUBB) ? s_r.c : sub_op;
		s5 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + 5'(cin);
		s9 = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + 9'(cin);
		s17 = {1'b0, a} + {1'b0, bx} + 17'(cin);
		is_shift = op == OP_ASR || op == OP_LSR || op == OP_SL;
		sh_src = byte_op ? {{8{a[7] && op == OP_ASR}}, a[7:0]} : a;
		// The mask is indexed by status bit position, so it spans up to the half carry bit.
		aff = 9'h000;
		r = s17[15:0];
		cv = byte_op ? s9[8] : s17[16];
		hv = byte_op ? s5[4] : s9[8];
		unique case (op)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
				aff = 9'h10F;
			end
			OP_AND: begin
				r = a & b;
				aff = 9'h00A;
			end
			OP_IOR: begin
				r = a | b;
				aff = 9'h00A;
			end
			OP_XOR: begin
				r = a ^ b;
				aff = 9'h00A;
			end
			OP_ASR: begin
				r = 16'($signed(sh_src) >>> b[3:0]);
				cv = a[0];
			end
			OP_LSR: begin
				r = sh_src >> b[3:0];
				cv = a[0];
			end
			OP_SL: begin
				r = sh_src << b[3:0];
				cv = byte_op ? a[7] : a[15];
			end
			default: begin
				r = s17[15:0];
			end
		endcase
		if (is_shift) begin
			// A single-place shift also reports the bit that fell out.
			aff = (b[3:0] == 4'h1) ? 9'h00B : 9'h00A;
		end
		if (byte_op) begin
			r = {a[15:8], r[7:0]};
		end
		sgn = byte_op ? r[7] : r[15];
		zer = byte_op ? (r[7:0] == 8'h00) : (r == 16'h0000);
		ovv = byte_op ? (a[7] == bx[7]) && (r[7] != a[7])
			: (a[15] == bx[15]) && (r[15] != a[15]);
		// The multiplier works on 17-bit signed values.
		unique case (calu_mmode_t'(w16[CF_MUL+:3]))
			MM_SS, MM_SU, MM_SL: ma = {a[15], a};
			MM_B8: ma = {9'h000, a[7:0]};
			default: ma = {1'b0, a};
		endcase
		unique case (calu_mmode_t'(w16[CF_MUL+:3]))
			MM_SS, MM_US: mb = {b[15], b};
			MM_SL, MM_UL: mb = {12'h000, b[4:0]};
			MM_B8: mb = {9'h000, b[7:0]};
			default: mb = {1'b0, b};
		endcase
		prod = 34'($signed(ma) * $signed(mb));
		dsg = w16[CF_DSGN];
		dvd = w16[CF_DLONG] ? {s_r.dhi, s_r.opa}
			: {dsg ? {16{s_r.opa[15]}} : 16'h0000, s_r.opa};
		absd = (dsg && dvd[31]) ? 32'(-dvd) : dvd;
		cmd_ok = s_r.st == ST_IDLE && op <= OP_DIV
			&& !(is_shift && (w16[CF_SRCM] || w16[CF_DSTM]));
		exec = wr_go && wa == A_CMD && cmd_ok;
		if (wr_go) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			case (wa)
				A_STATUS: begin
					s_nxt.dc = wd[SB_DC];
					s_nxt.n = wd[SB_N];
					s_nxt.ov = wd[SB_OV];
					s_nxt.z = wd[SB_Z];
					s_nxt.c = wd[SB_C];
					if (!s_r.nesting_disable) begin
						s_nxt.ipl = wd[SB_IPL+:3];
					end
				end
				A_CTRL: begin
					if (!wd[CB_CPU_PRIORITY_HIGH_BIT]) begin
						s_nxt.cpu_priority_high_bit = 1'b0;
					end
				end
				A_OPA: s_nxt.opa = wmerge(s_r.opa, wd, ws);
				A_OPB: s_nxt.opb = wmerge(s_r.opb, wd, ws);
				A_OPM: s_nxt.opm = wmerge(s_r.opm, wd, ws);
				A_DHI: s_nxt.dhi = wmerge(s_r.dhi, wd, ws);
				A_MISC: s_nxt.nesting_disable = wd[MB_NESTING_DISABLE];
				A_PADR: begin
					s_nxt.padr = wd[23:0];
					s_nxt.ptbl = wd[PB_TBL];
					s_nxt.ppage = wd[PB_PAGE];
					s_nxt.pok = !wd[23] || (wd[PB_TBL] && wd[PB_PAGE]);
				end
				A_CMD: begin
					s_nxt.err = !cmd_ok;
					if (!cmd_ok) begin
						s_nxt.bresp = RESP_SLVERR;
					end
				end
				A_RLO, A_RHI: begin
				end
				default: s_nxt.bresp = RESP_SLVERR;
			endcase
		end
		if (exec) begin
			s_nxt.cmd = w16;
			s_nxt.dst = w16[CF_DSTM];
			if (op == OP_MUL) begin
				s_nxt.res_lo = prod[15:0];
				s_nxt.res_hi = prod[31:16];
			end else if (op == OP_DIV) begin
				s_nxt.st = ST_DIV;
				s_nxt.cnt = 5'h00;
				s_nxt.rem = absd[31:16];
				s_nxt.quo = absd[15:0];
				s_nxt.dvs = (dsg && b[15]) ? 16'(-b) : b;
				s_nxt.neg_q = dsg && (dvd[31] ^ b[15]);
				s_nxt.neg_r = dsg && dvd[31];
			end else begin
				s_nxt.res_lo = r;
			end
			// Untouched flags keep their value.
			if (aff[SB_DC]) begin
				s_nxt.dc = hv;
			end
			if (aff[SB_N]) begin
				s_nxt.n = sgn;
			end
			if (aff[SB_OV]) begin
				s_nxt.ov = ovv;
			end
			if (aff[SB_C]) begin
				s_nxt.c = cv;
			end
			if (aff[SB_Z]) begin
				// Chained operations can only clear zero, so a multiword zero test works.
				s_nxt.z = (op == OP_ADDC || op == OP_SUBB) ? (s_r.z && zer) : zer;
			end
		end
		// One restoring step per divisor bit; hold freezes it for an interrupt.
		t = {s_r.rem, s_r.quo[15]};
		qf = s_r.neg_q ? 16'(-s_r.quo) : s_r.quo;
		rf = s_r.neg_r ? 16'(-s_r.rem) : s_r.rem;
		unique case (s_r.st)
			ST_IDLE: begin
			end
			ST_DIV: begin
				if (!div_hold) begin
					if (t >= {1'b0, s_r.dvs}) begin
						s_nxt.rem = 16'(t - {1'b0, s_r.dvs});
						s_nxt.quo = {s_r.quo[14:0], 1'b1};
					end else begin
						s_nxt.rem = t[15:0];
						s_nxt.quo = {s_r.quo[14:0], 1'b0};
					end
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (s_r.cnt == DIV_LAST) begin
						s_nxt.st = ST_FIX;
					end
				end
			end
			ST_FIX: begin
				if (!div_hold) begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (s_r.cnt == DIV_CYCLES - 5'h01) begin
						s_nxt.st = ST_IDLE;
						s_nxt.res_lo = qf;
						s_nxt.res_hi = rf;
						s_nxt.n = qf[15];
						s_nxt.z = qf == 16'h0000;
					end
				end
			end
		endcase
		if (!s_r.rvalid && s_axi_arvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				A_STATUS: s_nxt.rdata = 32'(status_word(s_r));
				A_CTRL: s_nxt.rdata = 32'(ctrl_word(s_r));
				A_OPA: s_nxt.rdata = 32'(s_r.opa);
				A_OPB: s_nxt.rdata = 32'(s_r.opb);
				A_OPM: s_nxt.rdata = 32'(s_r.opm);
				A_DHI: s_nxt.rdata = 32'(s_r.dhi);
				A_CMD: s_nxt.rdata = 32'(s_r.cmd);
				A_RLO: s_nxt.rdata = 32'(s_r.res_lo);
				A_RHI: s_nxt.rdata = 32'(s_r.res_hi);
				A_MISC: s_nxt.rdata = 32'({s_r.err, s_r.dst, s_r.st != ST_IDLE, s_r.nesting_disable});
				A_PADR: s_nxt.rdata = {s_r.pok, 5'h00, s_r.ppage, s_r.ptbl, s_r.padr};
				default: s_nxt.rresp = RESP_SLVERR;
			endcase
		end
		// Hardware priority updates win over a software write in the same cycle.
		if (hw_ipl_load) begin
			s_nxt.ipl = hw_ipl_value[2:0];
			s_nxt.cpu_priority_high_bit = hw_ipl_value[3];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.pok <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Helper state for the checks below.
	logic [5:0] h_len;
	logic h_held;
	logic [31:0] h_dvd;
	logic [15:0] h_dvs;
	logic h_uns;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_len <= 6'h00;
			h_held <= 1'b0;
			h_dvd <= 32'h0000_0000;
			h_dvs <= 16'h0000;
			h_uns <= 1'b0;
		end else if (exec && op == OP_DIV) begin
			h_len <= 6'h00;
			h_held <= 1'b0;
			h_dvd <= dvd;
			h_dvs <= b;
			h_uns <= !dsg;
		end else if (s_r.st != ST_IDLE) begin
			h_len <= h_len + 6'h01;
			h_held <= h_held || div_hold;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_div_length: assert property ($fell(alu_busy) && !h_held |-> h_len == 6'(DIV_CYCLES))
		else $error("divide did not take 19 cycles");
	chk_div_result: assert property ($fell(alu_busy) && h_uns && h_dvs != 16'h0000
		&& h_dvd[31:16] < h_dvs |-> 32'(s_r.res_lo) * 32'(h_dvs) + 32'(s_r.res_hi) == h_dvd
		&& s_r.res_hi < h_dvs)
		else $error("unsigned quotient or remainder wrong");
	chk_ipl_locked: assert property (wr_go && wa == A_STATUS && s_r.nesting_disable && !hw_ipl_load
		|=> s_r.ipl == $past(s_r.ipl))
		else $error("priority bits changed while locked");
	chk_cpu_priority_high_bit_clear: assert property (!s_r.cpu_priority_high_bit && !hw_ipl_load |=> !s_r.cpu_priority_high_bit)
		else $error("software set the priority high bit");
	chk_ctrl_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_CTRL
		|=> s_axi_rvalid && s_axi_rdata[2] && s_axi_rdata[31:4] == 28'h0 && !s_axi_rdata[1]
		&& !s_axi_rdata[0])
		else $error("control word fixed bits wrong");
	chk_sub_borrow: assert property (exec && op == OP_SUB && !byte_op
		|=> s_r.c == ($past(a) >= $past(b)))
		else $error("subtract carry is not inverted borrow");
	chk_zero_sticky: assert property (exec && op == OP_ADDC && !zer |=> !s_r.z)
		else $error("chained nonzero result left zero set");
	chk_prog_limit: assert property (wr_go && wa == A_PADR && wd[23] && !wd[PB_TBL]
		|=> !prog_access_ok)
		else $error("upper program space reachable by user");
	chk_shift_refuse: assert property (wr_go && wa == A_CMD && is_shift && w16[CF_SRCM]
		|=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
		else $error("memory operand accepted for shift");
	chk_loop_flag: assert property (loop_active ##1 loop_active |-> s_r.ra)
		else $error("loop active flag not shown");

	cov_div_done: cover property ($fell(alu_busy));
	cov_div_held: cover property (alu_busy && div_hold ##1 alu_busy);
	cov_mul_exec: cover property (exec && op == OP_MUL);
	cov_hw_ipl: cover property (hw_ipl_load && hw_ipl_value[3]);
endmodule

// *** verification/calu_core_model.sv ***
// Behavioural model of the core sequencer that drives the datapath side inputs.
`timescale 1ns/10ps
module calu_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic alu_busy,
	input wire logic loop_req,
	input wire logic ipl_req,
	input wire logic [3:0] ipl_val,
	input wire logic [3:0] hold_len,
	output logic loop_active,
	output logic hw_ipl_load,
	output logic [3:0] hw_ipl_value,
	output logic div_hold
);
	logic [5:0] busy_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= 6'h00;
			div_hold <= 1'b0;
			loop_active <= 1'b0;
			hw_ipl_load <= 1'b0;
			hw_ipl_value <= 4'hF;
		end else begin
			busy_r <= alu_busy ? busy_r + 6'h01 : 6'h00;
			// An interrupt taken mid divide freezes it for hold_len cycles.
			div_hold <= alu_busy && busy_r >= 6'h04 && busy_r < 6'h04 + 6'(hold_len);
			loop_active <= loop_req;
			hw_ipl_load <= ipl_req;
			// The value is scrambled outside a load so a stale copy cannot pass.
			hw_ipl_value <= ipl_req ? ipl_val : ~ipl_val;
		end
	end
endmodule

// *** verification/calu_datapath_bench.sv ***
// Self-checking bench for the ALU status datapath and its register slave.
`timescale 1ns/10ps
module calu_datapath_bench;
	import calu_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic loop_active, hw_ipl_load, div_hold, alu_busy, result_to_mem, prog_access_ok;
	logic [3:0] hw_ipl_value, cpu_priority_level, ipl_val = 4'h0, hold_len = 4'h0;
	logic loop_req = 1'b0, ipl_req = 1'b0;
	int err_count = 0, n_compared = 0, busy_cnt = 0;
	always #12.5 aclk = ~aclk;
	calu_datapath uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loop_active,
		.hw_ipl_load, .hw_ipl_value, .div_hold, .cpu_priority_level, .alu_busy,
		.result_to_mem, .prog_access_ok);
	calu_core_model core (.aclk, .aresetn, .alu_busy, .loop_req, .ipl_req, .ipl_val,
		.hold_len, .loop_active, .hw_ipl_load, .hw_ipl_value, .div_hold);
	always @(negedge aclk) begin
		if (alu_busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Handshakes are judged at the falling edge, where both sides are settled.
	task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		int n;
		n = 0;
		b_t = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!b_t && n < 40) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = (s_axi_bvalid === 1'b1);
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
		end
		chk("bvalid", 32'(b_t), 32'h1);
		chk("bresp", 32'(r), 32'(er));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wx(a, d, RESP_OKAY);
	endtask
	task automatic rx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
		logic ar_t, r_t;
		int n;
		n = 0;
		r_t = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!r_t && n < 40) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = (s_axi_rvalid === 1'b1);
			d = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			n++;
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] d;
		logic [1:0] rr;
		rx(a, d, rr);
		chk(nm, d, exp);
	endtask
	task automatic op(input logic [15:0] pre, a, b, cmd, res, st);
		wr(A_STATUS, 32'(pre));
		wr(A_OPA, 32'(a));
		wr(A_OPB, 32'(b));
		wr(A_CMD, 32'(cmd));
		rc(A_RLO, 32'(res), "result");
		rc(A_STATUS, 32'(st), "status");
	endtask
	task automatic t_reset;
		rc(A_STATUS, 32'h0, "status");
		rc(A_CTRL, 32'h4, "ctrl");
		chk("prog_ok", 32'(prog_access_ok), 32'h1);
		chk("level", 32'(cpu_priority_level), 32'h0);
	endtask
	task automatic t_arith;
		op(16'h0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000, 16'h0103);
		op(16'h0, 16'h127F, 16'h0001, 16'h0010, 16'h1280, 16'h010C);
		op(16'h0, 16'h7FFF, 16'h0001, 16'h0000, 16'h8000, 16'h010C);
		op(16'h0, 16'h0005, 16'h0003, 16'h0002, 16'h0002, 16'h0101);
		op(16'h0, 16'h0003, 16'h0005, 16'h0002, 16'hFFFE, 16'h0008);
		op(16'h0, 16'h0010, 16'h0001, 16'h0012, 16'h000F, 16'h0001);
		op(16'h2, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0002);
		op(16'h2, 16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0000);
		op(16'h3, 16'h0005, 16'h0005, 16'h0003, 16'h0000, 16'h0103);
		wx(A_CMD, 32'h000C, RESP_SLVERR);
	endtask
	task automatic t_logic_shift;
		op(16'h0105, 16'hF0F0, 16'h0F0F, 16'h0004, 16'h0000, 16'h0107);
		op(16'h0105, 16'h8000, 16'h0001, 16'h0005, 16'h8001, 16'h010D);
		op(16'h0105, 16'hFFFF, 16'hFFFF, 16'h0006, 16'h0000, 16'h0107);
		op(16'h0000, 16'h8001, 16'h0001, 16'h0007, 16'hC000, 16'h0009);
		op(16'h0001, 16'h8001, 16'h000F, 16'h0008, 16'h0001, 16'h0001);
		op(16'h0000, 16'h8001, 16'h000F, 16'h0009, 16'h8000, 16'h0008);
		wx(A_CMD, 32'h0027, RESP_SLVERR);
		wx(A_CMD, 32'h0049, RESP_SLVERR);
	endtask
	task automatic t_mul;
		logic [31:0] ex [7] = '{32'h00000002, 32'hFFFD0002, 32'hFFFF0002, 32'hFFFE0002,
			32'hFFFFFFE2, 32'h001DFFE2, 32'h0000FD02};
		logic [31:0] lo, hi;
		logic [1:0] rr;
		wr(A_OPA, 32'hFFFF);
		wr(A_OPB, 32'hFFFE);
		for (int m = 0; m < 7; m++) begin
			wr(A_CMD, 32'(32'h000A | (m << 8)));
			rx(A_RLO, lo, rr);
			rx(A_RHI, hi, rr);
			chk("product", {hi[15:0], lo[15:0]}, ex[m]);
		end
	endtask
	task automatic div_run(input logic [15:0] hi, a, b, cmd, q, r, input logic [3:0] hl);
		int n;
		int b0;
		wr(A_DHI, 32'(hi));
		wr(A_OPA, 32'(a));
		wr(A_OPB, 32'(b));
		hold_len <= hl;
		// The busy counter has one writer; this divide is measured from a snapshot.
		b0 = busy_cnt;
		wr(A_CMD, 32'(cmd));
		wx(A_CMD, 32'h0000, RESP_SLVERR);
		n = 0;
		while (alu_busy !== 1'b0 && n < 100) begin
			@(negedge aclk);
			n++;
		end
		@(posedge aclk);
		chk("div_cycles", 32'(busy_cnt - b0), 32'(19 + hl));
		rc(A_RLO, 32'(q), "quotient");
		rc(A_RHI, 32'(r), "remainder");
	endtask
	task automatic t_div;
		div_run(16'h0001, 16'h0000, 16'h0007, 16'h100B, 16'h2492, 16'h0002, 4'h0);
		div_run(16'h0000, 16'hFFF9, 16'h0002, 16'h080B, 16'hFFFD, 16'hFFFF, 4'h3);
	endtask
	task automatic t_ipl;
		wr(A_STATUS, 32'h0);
		ipl_val <= 4'hA;
		ipl_req <= 1'b1;
		@(posedge aclk);
		ipl_req <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("level", 32'(cpu_priority_level), 32'hA);
		rc(A_CTRL, 32'h000C, "ctrl");
		rc(A_STATUS, 32'h0040, "status");
		wr(A_CTRL, 32'h0008);
		rc(A_CTRL, 32'h000C, "ctrl");
		wr(A_CTRL, 32'h0000);
		rc(A_CTRL, 32'h0004, "ctrl");
		wr(A_STATUS, 32'h00E0);
		chk("level", 32'(cpu_priority_level), 32'h7);
		wr(A_MISC, 32'h1);
		wr(A_STATUS, 32'h0000);
		rc(A_STATUS, 32'h00E0, "status");
		wr(A_MISC, 32'h0);
		wr(A_STATUS, 32'hFFFF);
		rc(A_STATUS, 32'h01EF, "status");
		loop_req <= 1'b1;
		repeat (3) @(posedge aclk);
		rc(A_STATUS, 32'h01FF, "status");
		loop_req <= 1'b0;
	endtask
	task automatic t_space;
		logic [31:0] pa [4] = '{32'h007FFFFF, 32'h00800000, 32'h03800000, 32'h01FFFFFF};
		logic [3:0] ok = 4'h5;
		logic [31:0] d;
		logic [1:0] rr;
		for (int i = 0; i < 4; i++) begin
			wr(A_PADR, pa[i]);
			chk("prog_ok", 32'(prog_access_ok), 32'(ok[i]));
		end
		wr(A_OPM, 32'h0010);
		op(16'h0, 16'h0F00, 16'h0001, 16'h0020, 16'h0011, 16'h0000);
		chk("to_mem", 32'(result_to_mem), 32'h0);
		wr(A_CMD, 32'h0040);
		chk("to_mem", 32'(result_to_mem), 32'h1);
		wx(8'h40, 32'h1, RESP_SLVERR);
		rx(8'h40, d, rr);
		chk("rresp", 32'(rr), 32'(RESP_SLVERR));
		chk("rdata", d, 32'h0);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_arith();
		t_logic_shift();
		t_mul();
		t_div();
		t_space();
		t_ipl();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		complete_run();
	end
endmodule
